/* cfl_top.sv */
// cfl_top: drift detection, frequency request filter, lock debounce, phase aligner
`timescale 1ns/1ps
// Function
// - quadrant from filtered early/late votes only
// - quadrant changes give faster/slower indications
// - enable bit gates drift until quadrant seen
// - signed counter, +1 slower, -1 faster
// - within ten percent sets match flag
// - matched: request only beyond half range
// - beyond ninety percent clears match flag
// - match flag is set/reset storage
// - match drops when data stops or mismatches
// - control signal accompanies each change request
// - locked after match high N cycles
// - unlocked after match low N cycles
// - bang-bang detector yields raw early/late
// - aligner window generated internally, parameter length
// - phase decisions become phase-shift port handshake
// - phase aligner adjusts continuously while running
// - quadrant up means too fast, down slow
// - decide only above half window transitions
// - phase decisions stretched, typically three cycles
// - change request stands over eight periods
module cfl_top
	import cfl_pkg::*;
#(
	parameter int CNT_W = CFL_CNT_W,
	parameter int WIN_BITS = CFL_WIN_BITS,
	parameter int MIN_BITS = CFL_MIN_BITS,
	parameter int STRETCH = CFL_STRETCH,
	parameter int REQ_HOLD = CFL_REQ_HOLD,
	parameter int LOCK_N = CFL_LOCK_N,
	parameter int IDLE_MAX = CFL_IDLE_MAX
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic i_dat,
	input wire logic i_edg,
	input wire logic q_dat,
	input wire logic q_edg,
	input wire logic r_dat,
	input wire logic r_edg,
	input wire logic ps_done,
	output logic faster_q,
	output logic slower_q,
	output cfl_quad_t quadrant_q,
	output logic freq_match_q,
	output logic freq_req_en_q,
	output logic freq_req_inc_q,
	output logic freq_req_ctl_q,
	output logic cdr_locked_q,
	output logic ps_en_q,
	output logic ps_incdec_q
);
	// ----------------------------------------------------------------
	// derived thresholds
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] CMAX = CNT_W'((1 << (CNT_W - 1)) - 1);
	localparam logic [CNT_W-1:0] CMIN = CNT_W'(0) - CMAX;
	localparam logic [CNT_W-1:0] LOCK_T = CNT_W'(CMAX * CFL_LOCK_PCT / CFL_PCT_FULL);
	localparam logic [CNT_W-1:0] ACT_T = CNT_W'(CMAX * CFL_ACT_PCT / CFL_PCT_FULL);
	localparam logic [CNT_W-1:0] UNLK_T = CNT_W'(CMAX * CFL_UNLK_PCT / CFL_PCT_FULL);
	localparam int RW = $clog2(REQ_HOLD + 1); // request hold counter width
	localparam int DW = $clog2(LOCK_N + 1); // debounce counter width
	localparam int IW = $clog2(IDLE_MAX + 1); // idle counter width

	logic [CFL_NCH-1:0] dat_v; // data samples per channel
	logic [CFL_NCH-1:0] edg_v; // edge samples per channel
	logic [CFL_NCH-1:0] prv_q; // previous data sample
	logic [CFL_NCH-1:0] trn_q; // raw transition
	logic [CFL_NCH-1:0] ear_q; // raw early
	logic [CFL_NCH-1:0] lat_q; // raw late
	logic [CFL_NCH-1:0] f_up; // filtered early
	logic [CFL_NCH-1:0] f_dn; // filtered late
	logic [CFL_NCH-1:0] f_vld; // filtered decision pulse
	logic [WIN_BITS-1:0] mwin_q; // master window for I/Q
	logic mwin_end; // master window end
	logic i_late_q; // last I decision
	logic q_late_q; // last Q decision
	logic i_seen_q; // I decided since idle
	logic q_seen_q; // Q decided since idle
	logic seen_q; // drift enable bit
	logic il_n; // I decision this cycle
	logic ql_n; // Q decision this cycle
	logic quad_new; // new quadrant ready
	cfl_quad_t qn; // quadrant from decisions
	logic [IW-1:0] idle_q; // cycles without edges
	logic stopped_q; // data stopped
	logic signed [CNT_W-1:0] cnt_q; // frequency filter counter
	logic [CNT_W-1:0] mag; // counter magnitude
	logic fwd; // forward a change request
	logic [RW-1:0] rq_q; // request hold remaining
	logic [DW-1:0] dbc_q; // debounce count
	cfl_ps_e ps_q; // phase step state

	assign dat_v = {r_dat, q_dat, i_dat};
	assign edg_v = {r_edg, q_edg, i_edg};
	assign mwin_end = (mwin_q == '0);

	// ----------------------------------------------------------------
	// detectors and vote filters per channel
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CFL_NCH; g++) begin : g_ch
			// edge sample equal to old data means clock early
			always_ff @(posedge mclk) begin
				if (!nrst) begin
					prv_q[g] <= 1'b0;
					trn_q[g] <= 1'b0;
					ear_q[g] <= 1'b0;
					lat_q[g] <= 1'b0;
				end else if (ce) begin
					prv_q[g] <= dat_v[g];
					trn_q[g] <= dat_v[g] != prv_q[g];
					ear_q[g] <= (dat_v[g] != prv_q[g]) && (edg_v[g] == prv_q[g]);
					lat_q[g] <= (dat_v[g] != prv_q[g]) && (edg_v[g] != prv_q[g]);
				end
			end
			// aligner channel counts its own window
			cfl_vote_filter #(
				.WIN_BITS(WIN_BITS),
				.MIN_BITS(MIN_BITS),
				.STRETCH(STRETCH),
				.INT_WIN(g == CFL_CH_R)
			) u_filt (
				.mclk(mclk),
				.nrst(nrst),
				.ce(ce),
				.ext_win_end(mwin_end),
				.trans(trn_q[g]),
				.early(ear_q[g]),
				.late(lat_q[g]),
				.up_q(f_up[g]),
				.dn_q(f_dn[g]),
				.vld_q(f_vld[g])
			);
		end
	endgenerate

	// master window shared by I and Q filters
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mwin_q <= '0;
		end else if (ce) begin
			mwin_q <= mwin_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// quadrant and drift
	// ----------------------------------------------------------------
	// quadrant only from filtered decisions
	always_comb begin
		il_n = f_vld[CFL_CH_I] ? f_dn[CFL_CH_I] : i_late_q;
		ql_n = f_vld[CFL_CH_Q] ? f_dn[CFL_CH_Q] : q_late_q;
		quad_new = (f_vld[CFL_CH_I] || f_vld[CFL_CH_Q])
			&& (i_seen_q || f_vld[CFL_CH_I]) && (q_seen_q || f_vld[CFL_CH_Q]);
		case ({il_n, ql_n})
			2'h0: qn = 2'h0;
			2'h1: qn = 2'h1;
			2'h3: qn = 2'h2;
			default: qn = 2'h3;
		endcase
	end

	// held decisions; seen flags cleared when the data goes idle
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			i_late_q <= 1'b0;
			q_late_q <= 1'b0;
			i_seen_q <= 1'b0;
			q_seen_q <= 1'b0;
		end else if (ce) begin
			i_late_q <= il_n;
			q_late_q <= ql_n;
			i_seen_q <= !stopped_q && (i_seen_q || f_vld[CFL_CH_I]);
			q_seen_q <= !stopped_q && (q_seen_q || f_vld[CFL_CH_Q]);
		end
	end

	// set/reset enable, set on first quadrant
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			seen_q <= 1'b0;
		end else if (ce) begin
			if (quad_new) begin
				seen_q <= 1'b1;
			end else if (stopped_q) begin
				seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			quadrant_q <= 2'h0;
			faster_q <= 1'b0;
			slower_q <= 1'b0;
		end else if (ce) begin
			faster_q <= 1'b0;
			slower_q <= 1'b0;
			if (quad_new) begin
				quadrant_q <= qn;
				// upward too fast, downward too slow
				if (seen_q) begin
					faster_q <= qn == quadrant_q + 2'h1;
					slower_q <= qn == quadrant_q - 2'h1;
				end
			end
		end
	end

	// data stopped after idle period without edges
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			idle_q <= '0;
			stopped_q <= 1'b0;
		end else if (ce) begin
			if (trn_q[CFL_CH_I]) begin
				idle_q <= '0;
				stopped_q <= 1'b0;
			end else if (idle_q == IW'(IDLE_MAX - 1)) begin
				stopped_q <= 1'b1;
			end else begin
				idle_q <= idle_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// frequency request filter
	// ----------------------------------------------------------------
	// beyond activate while matched, else beyond unlock
	always_comb begin
		mag = cnt_q[CNT_W-1] ? CNT_W'(-cnt_q) : CNT_W'(cnt_q);
		fwd = ce && !freq_req_en_q && (mag > (freq_match_q ? ACT_T : UNLK_T));
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (fwd) begin
			// back to centre after a request
			cnt_q <= '0;
		end else if (ce) begin
			if (slower_q && cnt_q != CMAX) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (faster_q && cnt_q != CMIN) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			freq_match_q <= 1'b0;
		end else if (ce) begin
			// clear beyond unlock, or when data stops
			if (stopped_q || mag > UNLK_T) begin
				freq_match_q <= 1'b0;
			end else if (seen_q && mag <= LOCK_T) begin
				freq_match_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			freq_req_en_q <= 1'b0;
			freq_req_inc_q <= 1'b0;
			freq_req_ctl_q <= 1'b0;
			rq_q <= '0;
		end else if (fwd) begin
			freq_req_en_q <= 1'b1;
			freq_req_inc_q <= !cnt_q[CNT_W-1];
			freq_req_ctl_q <= 1'b1;
			rq_q <= RW'(REQ_HOLD - 1);
		end else if (ce) begin
			if (rq_q != '0) begin
				rq_q <= rq_q - 1'b1;
			end else begin
				freq_req_en_q <= 1'b0;
				freq_req_inc_q <= 1'b0;
				freq_req_ctl_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// lock debouncer
	// ----------------------------------------------------------------
	// flip only after LOCK_N steady cycles
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			dbc_q <= '0;
			cdr_locked_q <= 1'b0;
		end else if (ce) begin
			if (freq_match_q == cdr_locked_q) begin
				dbc_q <= '0;
			end else if (dbc_q == DW'(LOCK_N - 1)) begin
				dbc_q <= '0;
				cdr_locked_q <= freq_match_q;
			end else begin
				dbc_q <= dbc_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// phase step controller
	// ----------------------------------------------------------------
	// one-cycle enable, then wait for done
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ps_q <= CFL_PS_IDLE;
			ps_en_q <= 1'b0;
			ps_incdec_q <= 1'b0;
		end else if (ce) begin
			ps_en_q <= 1'b0;
			case (ps_q)
				CFL_PS_IDLE: begin
					if (f_vld[CFL_CH_R]) begin
						ps_en_q <= 1'b1;
						ps_incdec_q <= f_up[CFL_CH_R];
						ps_q <= CFL_PS_BUSY;
					end
				end
				CFL_PS_BUSY: begin
					if (ps_done) begin
						ps_q <= CFL_PS_IDLE;
					end
				end
				default: ps_q <= CFL_PS_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_drift_gate: assert property (@(posedge mclk) disable iff (!nrst)
		(ce && !seen_q) |=> (!faster_q && !slower_q))
		else $error("drift reported while disabled");
	a_lock_set: assert property (@(posedge mclk) disable iff (!nrst)
		(ce && seen_q && !stopped_q && mag <= LOCK_T) |=> freq_match_q)
		else $error("match not set inside lock window");
	a_unlock_clr: assert property (@(posedge mclk) disable iff (!nrst)
		(ce && mag > UNLK_T) |=> !freq_match_q)
		else $error("match not cleared beyond unlock");
	a_req_ctl: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(freq_req_en_q) |-> (freq_req_ctl_q throughout (freq_req_en_q [*3])))
		else $error("request without control");
	a_req_hold: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(freq_req_ctl_q) |-> freq_req_ctl_q [*8])
		else $error("request control too short");
	a_centre_ret: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(freq_req_en_q) |-> cnt_q == '0)
		else $error("counter not centred after request");
	a_sat_top: assert property (@(posedge mclk) disable iff (!nrst)
		(ce && cnt_q == CMAX && !fwd && slower_q) |=> cnt_q == CMAX)
		else $error("counter wrapped at top");
	a_lock_rise: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(cdr_locked_q) |-> ($past(freq_match_q) && $past(dbc_q) == DW'(LOCK_N - 1)))
		else $error("locked without full debounce");
	a_lock_fall: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(cdr_locked_q) |-> (!$past(freq_match_q) && $past(dbc_q) == DW'(LOCK_N - 1)))
		else $error("unlocked without full debounce");
	a_ps_pulse: assert property (@(posedge mclk) disable iff (!nrst)
		(ce && ps_en_q) |=> (!ps_en_q && ps_q == CFL_PS_BUSY))
		else $error("phase enable not a single pulse");
endmodule

/* cfl_pkg.sv */
// cfl_pkg: shared constants and types of the frequency-lock control block
package cfl_pkg;
	// ----------------------------------------------------------------
	// frequency request filter
	// ----------------------------------------------------------------
	localparam int CFL_CNT_W = 12; // width of signed up/down counter
	localparam int CFL_PCT_FULL = 100; // percent of full range
	localparam int CFL_LOCK_PCT = 10; // lock window
	localparam int CFL_ACT_PCT = 50; // activate window while matched
	localparam int CFL_UNLK_PCT = 90; // unlock threshold
	localparam int CFL_REQ_HOLD = 8; // cycles a change request stands
	localparam int CFL_IDLE_MAX = 1024; // cycles without edges = data stopped
	// ----------------------------------------------------------------
	// vote filters and debouncer
	// ----------------------------------------------------------------
	localparam int CFL_WIN_BITS = 6; // counting window is 2**bits cycles
	localparam int CFL_MIN_BITS = 3; // least transitions 2**bits per window
	localparam int CFL_STRETCH = 3; // cycles a decision is stretched
	localparam int CFL_LOCK_N = 64; // debounce length in cycles
	// ----------------------------------------------------------------
	// channels: in-phase, quadrature, phase aligner
	// ----------------------------------------------------------------
	localparam int CFL_NCH = 3;
	localparam int CFL_CH_I = 0;
	localparam int CFL_CH_Q = 1;
	localparam int CFL_CH_R = 2;
	typedef logic [1:0] cfl_quad_t; // data edge quadrant
	typedef enum logic {CFL_PS_IDLE, CFL_PS_BUSY} cfl_ps_e; // phase step states
endpackage

/* cfl_vote_filter.sv */
// cfl_vote_filter: windowed early/late vote counter with stretched decisions
`timescale 1ns/1ps
module cfl_vote_filter
	import cfl_pkg::*;
#(
	parameter int WIN_BITS = CFL_WIN_BITS,
	parameter int MIN_BITS = CFL_MIN_BITS,
	parameter int STRETCH = CFL_STRETCH,
	parameter bit INT_WIN = 1'b0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic ext_win_end,
	input wire logic trans,
	input wire logic early,
	input wire logic late,
	output logic up_q,
	output logic dn_q,
	output logic vld_q
);
	localparam int CW = WIN_BITS + 1; // counts up to a full window
	localparam int SW = $clog2(STRETCH + 1); // stretch counter width
	localparam logic [CW-1:0] MIN_TR = CW'(1 << MIN_BITS);

	logic [WIN_BITS-1:0] win_q; // own window counter
	logic [CW-1:0] ntr_q; // transitions in window
	logic [CW-1:0] ne_q; // early votes
	logic [CW-1:0] nl_q; // late votes
	logic [SW-1:0] st_q; // stretch remaining
	logic win_end; // last cycle of window
	logic take_up; // decide early
	logic take_dn; // decide late

	// window source: own counter or master's end mark
	assign win_end = INT_WIN ? (win_q == '0) : ext_win_end;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// free running window, used only when internal
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			win_q <= '0;
		end else if (ce) begin
			win_q <= win_q + 1'b1;
		end
	end

	// vote counters, cleared at each window end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ntr_q <= '0;
			ne_q <= '0;
			nl_q <= '0;
		end else if (ce) begin
			if (win_end) begin
				ntr_q <= '0;
				ne_q <= '0;
				nl_q <= '0;
			end else begin
				ntr_q <= ntr_q + CW'(trans);
				ne_q <= ne_q + CW'(early);
				nl_q <= nl_q + CW'(late);
			end
		end
	end

	// ----------------------------------------------------------------
	// decision
	// ----------------------------------------------------------------
	// majority over half the transitions
	always_comb begin
		take_up = win_end && (ntr_q >= MIN_TR) && (ne_q > (ntr_q >> 1));
		take_dn = win_end && (ntr_q >= MIN_TR) && (nl_q > (ntr_q >> 1)) && !take_up;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
			vld_q <= 1'b0;
			st_q <= '0;
		end else if (ce) begin
			vld_q <= take_up || take_dn;
			if (take_up || take_dn) begin
				up_q <= take_up;
				dn_q <= take_dn;
				st_q <= SW'(STRETCH - 1);
			end else if (st_q != '0) begin
				st_q <= st_q - 1'b1;
			end else begin
				up_q <= 1'b0;
				dn_q <= 1'b0;
			end
		end
	end

	a_vote_early: assert property (@(posedge mclk) disable iff (!nrst)
		(ce && win_end && ntr_q >= MIN_TR && ne_q > (ntr_q >> 1)) |=> (up_q && vld_q))
		else $error("early majority not decided");
	a_stretch_len: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(up_q) |-> up_q [*3])
		else $error("early decision not stretched");
endmodule

/* cfl_far_model.sv */
// cfl_far_model: behavioural clock manager phase-shift port and oscillator step logic
`timescale 1ns/1ps
module cfl_far_model
	import cfl_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ps_en,
	input wire logic [3:0] dly,
	input wire logic freq_req_en,
	input wire logic freq_req_inc,
	input wire logic freq_req_ctl,
	output logic ps_done,
	output logic signed [7:0] step_q
);
	// ------------------------------------------------------------
	// phase-shift port
	// ------------------------------------------------------------
	logic busy_q; // a phase step is in progress
	logic [3:0] wait_q; // cycles left before the step completes
	logic ctl_q; // control line one cycle ago

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			ps_done <= 1'b0;
		end else if (ps_en) begin
			busy_q <= 1'b1;
			wait_q <= dly;
			ps_done <= 1'b0;
		end else if (busy_q && wait_q == 4'h0) begin
			busy_q <= 1'b0;
			ps_done <= 1'b1;
		end else begin
			// count down the answer delay, done only pulses once
			if (busy_q) begin
				wait_q <= wait_q - 4'h1;
			end
			ps_done <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// oscillator step logic
	// ------------------------------------------------------------
	// step on control rise
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctl_q <= 1'b0;
			step_q <= 8'sh00;
		end else begin
			ctl_q <= freq_req_ctl;
			// only a control rise with enable moves the step size
			if (freq_req_ctl && !ctl_q && freq_req_en) begin
				step_q <= freq_req_inc ? step_q + 8'sh01 : step_q - 8'sh01;
			end
		end
	end
endmodule

/* tb_cfl_top.sv */
// tb_cfl_top: self-checking bench for the frequency-lock control block
`timescale 1ns/1ps
module tb_cfl_top
	import cfl_pkg::*;
	;
	// ------------------------------------------------------------
	// signals and bookkeeping
	// ------------------------------------------------------------
	localparam int WIN = 16; // window length with four window bits
	localparam int ACT = (2 ** 5 - 1) * CFL_ACT_PCT / CFL_PCT_FULL; // activate bound
	logic mclk, nrst, ce, ps_done;
	logic i_dat, i_edg, q_dat, q_edg, r_dat, r_edg, nd;
	logic faster_q, slower_q, freq_match_q, freq_req_en_q, freq_req_inc_q;
	logic freq_req_ctl_q, cdr_locked_q, ps_en_q, ps_incdec_q;
	cfl_quad_t quadrant_q;
	logic signed [7:0] step_q; // oscillator step seen by the far side
	logic [3:0] dly; // phase step answer delay
	logic run, stop, i_late, q_late, r_late, exp_dir, dir_ok, en_p;
	logic [1:0] cur; // last quadrant driven
	logic [4:0] snap; // outputs seen when the clock enable drops
	logic [3:0] drift_q[$]; // notes {faster, slower, quadrant}
	logic req_q[$]; // notes of request direction
	int err_total, num_checks, req_len, ps_cnt;

	cfl_top #(.CNT_W(6), .WIN_BITS(4), .MIN_BITS(2), .LOCK_N(4), .IDLE_MAX(32)) i_dut (
		.mclk(mclk), .nrst(nrst), .ce(ce), .i_dat(i_dat), .i_edg(i_edg),
		.q_dat(q_dat), .q_edg(q_edg), .r_dat(r_dat), .r_edg(r_edg),
		.ps_done(ps_done), .faster_q(faster_q), .slower_q(slower_q),
		.quadrant_q(quadrant_q), .freq_match_q(freq_match_q),
		.freq_req_en_q(freq_req_en_q), .freq_req_inc_q(freq_req_inc_q),
		.freq_req_ctl_q(freq_req_ctl_q), .cdr_locked_q(cdr_locked_q),
		.ps_en_q(ps_en_q), .ps_incdec_q(ps_incdec_q));

	cfl_far_model i_far (.mclk(mclk), .nrst(nrst), .ps_en(ps_en_q), .dly(dly),
		.freq_req_en(freq_req_en_q), .freq_req_inc(freq_req_inc_q),
		.freq_req_ctl(freq_req_ctl_q), .ps_done(ps_done), .step_q(step_q));

	// 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic wait_win(input int n);
		repeat (n * WIN) @(negedge mclk);
	endtask

	// drive a quadrant and note the drift pulse it should cause
	task automatic move(input logic [1:0] q);
		drift_q.push_back({q == cur + 2'h1, q == cur - 2'h1, q});
		i_late <= q[1];
		q_late <= q[1] ^ q[0];
		cur = q;
		wait_win(3);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// stimulus: toggling I/Q data, random aligner data, edge sample picks early or late
	// ------------------------------------------------------------
	always @(negedge mclk) begin
		if (run) begin
			// a stopped in-phase channel stands for lost data
			if (!stop) begin
				i_dat <= ~i_dat;
			end
			i_edg <= i_late ? ~i_dat : i_dat;
			q_dat <= ~q_dat;
			q_edg <= q_late ? ~q_dat : q_dat;
			nd = 1'($urandom);
			r_dat <= nd;
			r_edg <= r_late ? nd : r_dat;
		end
	end

	// ------------------------------------------------------------
	// monitor: takes the oldest note when a result appears
	// ------------------------------------------------------------
	always @(negedge mclk) begin
		if (nrst && (faster_q || slower_q)) begin
			chk("drift", 16'(drift_q.size() ? drift_q.pop_front() : 4'hX), 16'({faster_q, slower_q, quadrant_q}));
		end
		if (freq_req_en_q) begin
			if (!en_p) begin
				chk("request dir", 16'(req_q.size() ? req_q.pop_front() : 1'bx), 16'(freq_req_inc_q));
			end
			chk("request control", 16'(freq_req_en_q), 16'(freq_req_ctl_q));
			req_len++;
		end else if (en_p) begin
			chk("request length", 16'(CFL_REQ_HOLD), 16'(req_len));
			req_len = 0;
		end
		en_p = freq_req_en_q;
		if (ps_en_q) begin
			ps_cnt++;
			dly <= 4'($urandom_range(6));
			if (dir_ok) begin
				chk("step direction", 16'(exp_dir), 16'(ps_incdec_q));
			end
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{ce, nrst, run, stop, i_late, q_late, r_late, dir_ok, en_p} = 9'h100;
		{i_dat, i_edg, q_dat, q_edg, r_dat, r_edg, exp_dir} = 7'h01;
		err_total = 0;
		num_checks = 0;
		req_len = 0;
		ps_cnt = 0;
		dly = 4'h2;
		cur = 2'h0;
		void'($urandom(56710));
		repeat (4) @(negedge mclk);
		chk("reset outputs", 16'h0000, 16'({faster_q, slower_q, quadrant_q, freq_match_q, freq_req_en_q, cdr_locked_q, ps_en_q}));
		nrst <= 1'b1;
		run <= 1'b1;
		wait_win(3);
		chk("match after first quadrant", 16'h0001, 16'(freq_match_q));
		chk("locked", 16'h0001, 16'(cdr_locked_q));
		dir_ok <= 1'b1;
		// upward then downward quadrant moves
		for (int k = 1; k <= 4; k++) begin
			move(2'(k));
		end
		for (int k = 3; k >= 0; k--) begin
			move(2'(k));
		end
		dir_ok <= 1'b0;
		r_late <= 1'b1;
		wait_win(3);
		exp_dir <= 1'b0;
		dir_ok <= 1'b1;
		// one move beyond the activate window forwards a decrease
		for (int k = 1; k <= ACT + 1; k++) begin
			if (k == ACT + 1) begin
				req_q.push_back(1'b0);
			end
			move(2'(k));
		end
		chk("oscillator step", 16'hFFFF, 16'(step_q));
		chk("match kept", 16'h0001, 16'(freq_match_q));
		stop <= 1'b1;
		repeat (64) @(negedge mclk);
		chk("match on data stop", 16'h0000, 16'(freq_match_q));
		chk("unlocked", 16'h0000, 16'(cdr_locked_q));
		// clock enable low must freeze quadrant, match, lock and step direction
		snap = {quadrant_q, freq_match_q, cdr_locked_q, ps_incdec_q};
		ce <= 1'b0;
		repeat (10) @(negedge mclk);
		chk("frozen state", 16'(snap), 16'({quadrant_q, freq_match_q, cdr_locked_q, ps_incdec_q}));
		ce <= 1'b1;
		repeat (4) @(negedge mclk);
		chk("notes left", 16'h0000, 16'(drift_q.size() + req_q.size()));
		chk("phase steps seen", 16'h0001, 16'(ps_cnt > 0));
		give_verdict();
	end

	// watchdog cuts a hang short
	initial begin
		#20000;
		err_total++;
		$display("unexpected watchdog: expected finish seen timeout");
		give_verdict();
	end
endmodule
